/* File: core/pct_timer.v */
// 16-bit compare/capture/PWM timer with an APB register slave.
// Assumes one 40 MHz clock, synchronous active-high reset, APB master
// and capture input synchronous to clk_in.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pct_regs.vh"

module pct_timer
(
  input  wire                    clk_in,
  input  wire                    sys_rst_in,
  input  wire                    psel_in,
  input  wire                    penable_in,
  input  wire                    pwrite_in,
  input  wire [`PCT_ADDR_W-1:0]  paddr_in,
  input  wire [31:0]             pwdata_in,
  output reg  [31:0]             prdata_out,
  output reg                     pready_out,
  output reg                     pslverr_out,
  input  wire                    capture_in,
  output wire                    timer_out_out,
  output wire                    timer_out_n_out,
  output reg                     timer_irq_out
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [`PCT_CTRL_W-1:0] ctrl_reg;
  reg  [`PCT_CNT_W-1:0]  count_reg;
  reg  [`PCT_CNT_W-1:0]  count_next;
  reg  [`PCT_CNT_W-1:0]  reload_reg;
  reg  [`PCT_CNT_W-1:0]  pwm_reg;
  reg  [`PCT_CNT_W-1:0]  pwm_next;
  reg  [`PCT_DB_W-1:0]   db_reg;
  reg                    level_reg;
  reg                    level_next;
  reg                    irq_next;
  reg                    cap_prev_reg;
  reg                    cap_event;
  reg                    reload_event;
  reg  [31:0]            rd_mux;
  reg                    addr_ok;

  wire                   enable;
  wire [1:0]             mode;
  wire                   pol;
  wire [`PCT_PRE_W-1:0]  pre_sel;
  wire [1:0]             tic;
  wire                   out_en;
  wire                   tick;
  wire                   wr_acc;
  wire                   setup;
  wire [1:0]             db_target;
  wire [1:0]             db_pins;
  wire [`PCT_DB_W-1:0]   db_limited;

  assign enable  = ctrl_reg[`PCT_CTRL_EN];
  assign mode    = ctrl_reg[`PCT_CTRL_MODE_HI:`PCT_CTRL_MODE_LO];
  assign pol     = ctrl_reg[`PCT_CTRL_POL];
  assign pre_sel = ctrl_reg[`PCT_CTRL_PRE_HI:`PCT_CTRL_PRE_LO];
  assign tic     = ctrl_reg[`PCT_CTRL_TIC_HI:`PCT_CTRL_TIC_LO];
  assign out_en  = ctrl_reg[`PCT_CTRL_OUTEN];

  // --------------------------------------------------------------------
  // Interrupt source filter for capture mode
  // --------------------------------------------------------------------
  function irq_allowed;
    input [1:0] cfg;
    input       is_capture;
    begin
      case (cfg)
        `PCT_TIC_CAP_ONLY: irq_allowed = is_capture;
        `PCT_TIC_RLD_ONLY: irq_allowed = !is_capture;
        default:           irq_allowed = 1'b1;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------
  pct_prescaler u_pre
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (enable),
    .div_sel_in (pre_sel),
    .tick_out   (tick)
  );

  // --------------------------------------------------------------------
  // APB slave: one wait-free access phase, pready asserted every access
  // --------------------------------------------------------------------
  assign setup  = psel_in & ~penable_in;
  assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;

  always @*
  begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr_in)
      `PCT_OFF_CTRL:     rd_mux[`PCT_CTRL_W-1:0] = ctrl_reg;
      `PCT_OFF_COUNT:    rd_mux[`PCT_CNT_W-1:0]  = count_reg;
      `PCT_OFF_RELOAD:   rd_mux[`PCT_CNT_W-1:0]  = reload_reg;
      `PCT_OFF_PWM:      rd_mux[`PCT_CNT_W-1:0]  = pwm_reg;
      `PCT_OFF_DEADBAND: rd_mux[`PCT_DB_W-1:0]   = db_reg;
      `PCT_OFF_STATUS:   rd_mux[2:0] = {db_pins, level_reg};
      default:           addr_ok = 1'b0;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      // Ready and data are prepared in setup so the answer is a flop
      pready_out  <= setup;
      pslverr_out <= setup & ~addr_ok;
      if (setup && !pwrite_in)
        prdata_out <= rd_mux;
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_reg   <= `PCT_CTRL_RST;
      reload_reg <= `PCT_RELOAD_RST;
      db_reg     <= {`PCT_DB_W{1'b0}};
    end
    else if (wr_acc)
    begin
      // Setup order is left to software; enable takes effect on write
      if (paddr_in == `PCT_OFF_CTRL)
        ctrl_reg <= pwdata_in[`PCT_CTRL_W-1:0];
      if (paddr_in == `PCT_OFF_RELOAD)
        reload_reg <= pwdata_in[`PCT_CNT_W-1:0];
      if (paddr_in == `PCT_OFF_DEADBAND)
        db_reg <= pwdata_in[`PCT_DB_W-1:0];
    end
  end

  // Values above the longest deadband are clamped
  assign db_limited = (db_reg > `PCT_DB_MAX) ? `PCT_DB_MAX : db_reg;

  // --------------------------------------------------------------------
  // Event detection
  // --------------------------------------------------------------------
  always @*
  begin
    cap_event    = enable & (mode == `PCT_MODE_CAPTURE) &
                   capture_in & ~cap_prev_reg;
    reload_event = enable & tick & (count_reg == reload_reg);
  end

  // --------------------------------------------------------------------
  // Counter, output level and interrupt
  // --------------------------------------------------------------------
  always @*
  begin
    count_next = count_reg;
    pwm_next   = pwm_reg;
    level_next = level_reg;
    irq_next   = 1'b0;
    if (!enable)
      // Idle level is the programmed start level
      level_next = pol;
    else
    begin
      case (mode)
        `PCT_MODE_PWM, `PCT_MODE_DUAL:
        begin
          if (reload_event)
          begin
            count_next = `PCT_CNT_RESTART;
            level_next = pol;
            irq_next   = 1'b1;
          end
          else if (tick)
          begin
            // A start count other than 0001H just runs up to reload
            count_next = count_reg + `PCT_CNT_RESTART;
            if (count_reg == pwm_reg)
              level_next = ~level_reg;
          end
        end
        `PCT_MODE_CAPTURE:
        begin
          if (reload_event)
          begin
            count_next = `PCT_CNT_RESTART;
            irq_next   = irq_allowed(tic, 1'b0);
          end
          else if (tick)
            count_next = count_reg + `PCT_CNT_RESTART;
          if (cap_event)
          begin
            // Raw count; software scales by the prescale divisor
            pwm_next = count_reg;
            irq_next = irq_next | irq_allowed(tic, 1'b1);
          end
        end
        `PCT_MODE_COMPARE:
        begin
          if (tick)
          begin
            // Natural 16-bit wrap, no restart at the match
            count_next = count_reg + `PCT_CNT_RESTART;
            if (count_reg == reload_reg)
            begin
              irq_next   = 1'b1;
              level_next = ~level_reg;
            end
          end
        end
        default:
        begin
          count_next = count_reg;
        end
      endcase
    end
  end

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      count_reg     <= `PCT_CNT_RST;
      pwm_reg       <= `PCT_CNT_RST;
      level_reg     <= 1'b0;
      cap_prev_reg  <= 1'b0;
      timer_irq_out <= 1'b0;
    end
    else
    begin
      cap_prev_reg  <= capture_in;
      level_reg     <= level_next;
      timer_irq_out <= irq_next;
      // Software write of the count overrides counting
      if (wr_acc && paddr_in == `PCT_OFF_COUNT)
        count_reg <= pwdata_in[`PCT_CNT_W-1:0];
      else
        count_reg <= count_next;
      // A capture in the same cycle as a software write wins
      if (cap_event)
        pwm_reg <= pwm_next;
      else if (wr_acc && paddr_in == `PCT_OFF_PWM)
        pwm_reg <= pwdata_in[`PCT_CNT_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // Output pins with deadband
  // --------------------------------------------------------------------
  // The complement pin is only used in dual mode; the pins stay low
  // while the output function is disabled.
  assign db_target[0] = out_en & level_reg & (mode != `PCT_MODE_CAPTURE);
  assign db_target[1] = out_en & ~level_reg & enable &
                        (mode == `PCT_MODE_DUAL);

  pct_deadband u_db
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .target_in  (db_target),
    .delay_in   (db_limited),
    .pin_out    (db_pins)
  );

  assign timer_out_out   = db_pins[0];
  assign timer_out_n_out = db_pins[1];

endmodule // pct_timer

`default_nettype wire

/* File: core/pct_regs.vh */
// Register map, field layout and constants of the compare/capture/PWM timer.
// Assumes a 32-bit APB bus with word-aligned byte addresses.
`ifndef PCT_REGS_VH
`define PCT_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PCT_ADDR_W        8
`define PCT_OFF_CTRL      8'h00
`define PCT_OFF_COUNT     8'h04
`define PCT_OFF_RELOAD    8'h08
`define PCT_OFF_PWM       8'h0c
`define PCT_OFF_DEADBAND  8'h10
`define PCT_OFF_STATUS    8'h14

// ----------------------------------------------------------------------
// Control register fields (timer_control_one)
// ----------------------------------------------------------------------
`define PCT_CTRL_W        11
`define PCT_CTRL_EN       0
`define PCT_CTRL_MODE_HI  2
`define PCT_CTRL_MODE_LO  1
`define PCT_CTRL_POL      3
`define PCT_CTRL_PRE_HI   6
`define PCT_CTRL_PRE_LO   4
`define PCT_CTRL_TIC_HI   9
`define PCT_CTRL_TIC_LO   8
`define PCT_CTRL_OUTEN    10
`define PCT_CTRL_RST      11'h000

// Mode codes
`define PCT_MODE_PWM      2'h0
`define PCT_MODE_DUAL     2'h1
`define PCT_MODE_CAPTURE  2'h2
`define PCT_MODE_COMPARE  2'h3

// Interrupt configuration codes
`define PCT_TIC_CAP_ONLY  2'h2
`define PCT_TIC_RLD_ONLY  2'h3

// ----------------------------------------------------------------------
// Counter, deadband and prescaler constants
// ----------------------------------------------------------------------
`define PCT_CNT_W         16
`define PCT_CNT_RESTART   16'h0001
`define PCT_CNT_RST       16'h0000
`define PCT_RELOAD_RST    16'hffff
`define PCT_DB_W          8
`define PCT_DB_MAX        8'h80
`define PCT_PRE_W         3
`define PCT_PRE_CNT_W     7

`endif

/* File: core/pct_prescaler.v */
// Prescaler: divides the system clock by 2^div_sel (1 to 128).
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "pct_regs.vh"

module pct_prescaler
(
  input  wire                      clk_in,
  input  wire                      sys_rst_in,
  input  wire                      run_in,
  input  wire [`PCT_PRE_W-1:0]     div_sel_in,
  output wire                      tick_out
);

  reg  [`PCT_PRE_CNT_W-1:0] cnt_reg;
  wire [`PCT_PRE_CNT_W-1:0] term;

  // Terminal count is 2^n - 1, so the count runs 0 .. 2^n - 1
  assign term     = ~({`PCT_PRE_CNT_W{1'b1}} << div_sel_in);
  assign tick_out = run_in & (cnt_reg == term);

  always @(posedge clk_in)
  begin
    if (sys_rst_in || !run_in || tick_out)
      cnt_reg <= {`PCT_PRE_CNT_W{1'b0}};
    else
      cnt_reg <= cnt_reg + {{(`PCT_PRE_CNT_W-1){1'b0}}, 1'b1};
  end

endmodule // pct_prescaler

`default_nettype wire

/* File: core/pct_deadband.v */
// Deadband generator for a pair of outputs.
// Each output falls at once and rises only after its target has been
// high for deadband cycles. Assumes one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "pct_regs.vh"

module pct_deadband
(
  input  wire                  clk_in,
  input  wire                  sys_rst_in,
  input  wire [1:0]            target_in,
  input  wire [`PCT_DB_W-1:0]  delay_in,
  output wire [1:0]            pin_out
);

  genvar g;

  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chan
      reg [`PCT_DB_W-1:0] wait_reg;
      reg                 pin_reg;

      assign pin_out[g] = pin_reg;

      always @(posedge clk_in)
      begin
        if (sys_rst_in || !target_in[g])
        begin
          wait_reg <= {`PCT_DB_W{1'b0}};
          pin_reg  <= 1'b0;
        end
        else if (wait_reg >= delay_in)
          pin_reg  <= 1'b1;
        else
          wait_reg <= wait_reg + {{(`PCT_DB_W-1){1'b0}}, 1'b1};
      end
    end
  endgenerate

endmodule // pct_deadband

`default_nettype wire

/* File: bench/pct_timer_monitor.sv */
// Checker for pct_timer: bus handshake, irq pulse, output pair.
// Assumes pct_regs.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pct_regs.vh"

module pct_timer_monitor
(
  input wire logic                   clk_in,
  input wire logic                   sys_rst_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic                   pwrite_in,
  input wire logic [`PCT_ADDR_W-1:0] paddr_in,
  input wire logic [31:0]            pwdata_in,
  input wire logic [31:0]            prdata_out,
  input wire logic                   pready_out,
  input wire logic                   pslverr_out,
  input wire logic                   capture_in,
  input wire logic                   timer_out_out,
  input wire logic                   timer_out_n_out,
  input wire logic                   timer_irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  property p_rdy_next;
    psel_in && !penable_in |=> pready_out;
  endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("ready late");
  property p_rdy_cause;
    pready_out |-> $past(psel_in) && !$past(penable_in);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready unasked");
  property p_rdy_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  property p_err_rdy;
    pslverr_out |-> pready_out;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_err_zero;
    pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped data");

  // ------------------------------------------------------------
  // Timer outputs
  // ------------------------------------------------------------
  property p_irq_pulse;
    timer_irq_out |=> !timer_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_pair;
    !(timer_out_out && timer_out_n_out);
  endproperty
  a_pair: assert property (p_pair) else $error("both outputs high");
  // Two spare cycles let an event already under way finish
  property p_off_quiet;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == `PCT_OFF_CTRL
      && !pwdata_in[0] && pwdata_in[2:1] != `PCT_MODE_CAPTURE |=> ##2 !timer_irq_out [*6];
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("irq while off");
  property p_rst;
    disable iff (1'h0)
    sys_rst_in |=> !timer_irq_out && !pready_out && !timer_out_out && !timer_out_n_out;
  endproperty
  a_rst: assert property (p_rst) else $error("output high in reset");
endmodule // pct_timer_monitor

bind pct_timer pct_timer_monitor u_pct_timer_monitor (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .capture_in(capture_in), .timer_out_out(timer_out_out),
  .timer_out_n_out(timer_out_n_out), .timer_irq_out(timer_irq_out));

`default_nettype wire

/* File: bench/test_pwm_compare_capture_timer.sv */
// Self-checking bench for pct_timer: counts pin high time and irqs.
// Assumes pct_regs.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pct_regs.vh"

module test_pwm_compare_capture_timer;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        sel = 1'h0;
  logic        ena = 1'h0;
  logic        wr = 1'h0;
  logic        cap = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rv;
  logic        rdy, err, o, on, irq, ev;
  int          num_errors = 0;
  int          n_checks = 0;
  int          c_o = 0, c_on = 0, c_irq = 0;

  initial
    forever #12.5 clk = ~clk;

  // Running tallies; tests take differences so no process clears them
  always @(posedge clk)
  begin
    c_o <= c_o + o;
    c_on <= c_on + on;
    c_irq <= c_irq + irq;
  end

  pct_timer u_pct_timer (.clk_in(clk), .sys_rst_in(rst), .psel_in(sel), .penable_in(ena),
    .pwrite_in(wr), .paddr_in(addr), .pwdata_in(wdata), .prdata_out(rdata),
    .pready_out(rdy), .pslverr_out(err), .capture_in(cap), .timer_out_out(o),
    .timer_out_n_out(on), .timer_irq_out(irq));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1'h1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    ena <= 1'h1;
    @(posedge clk);
    while (rdy !== 1'h1)
      @(posedge clk);
    rv = rdata;
    ev = err;
    sel <= 1'h0;
    ena <= 1'h0;
  endtask

  task automatic cfg(input logic [10:0] c, input logic [15:0] n, r, p, input logic [7:0] db);
    apb(1'h1, `PCT_OFF_CTRL, {21'h0, c & 11'h7fe});
    apb(1'h1, `PCT_OFF_COUNT, {16'h0, n});
    apb(1'h1, `PCT_OFF_RELOAD, {16'h0, r});
    apb(1'h1, `PCT_OFF_PWM, {16'h0, p});
    apb(1'h1, `PCT_OFF_DEADBAND, {24'h0, db});
    apb(1'h1, `PCT_OFF_CTRL, {21'h0, c});
  endtask

  task automatic meas(input int n, output int a, b, q);
    a = c_o;
    b = c_on;
    q = c_irq;
    repeat (n) @(posedge clk);
    a = c_o - a;
    b = c_on - b;
    q = c_irq - q;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] e [5] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'h0, 8'(i * 4), 32'h0);
      chk(rv, e[i]);
      chk(ev, 1'h0);
    end
    apb(1'h1, 8'h18, 32'hffffffff);
    chk(ev, 1'h1);
    apb(1'h0, 8'h18, 32'h0);
    chk({ev, rv}, {1'h1, 32'h0});
    $display("register test done");
  endtask

  // Rows: ctrl, reload, pwm, deadband, cycles, out high, comp high, irqs
  task automatic t_pwm;
    // Output enable (bit 10) is set so the pins carry the level
    int t [5][8] = '{'{'h401, 5, 2, 0, 50, 30, 0, 10}, '{'h409, 5, 2, 0, 50, 20, 0, 10},
      '{'h429, 5, 2, 0, 200, 80, 0, 10}, '{'h403, 10, 5, 2, 100, 30, 30, 10},
      '{'h40b, 10, 3, 0, 100, 30, 70, 10}};
    int a, b, q;
    for (int i = 0; i < 5; i++)
    begin
      cfg(11'(t[i][0]), 16'h1, 16'(t[i][1]), 16'(t[i][2]), 8'(t[i][3]));
      repeat (t[i][4] / 5) @(posedge clk);
      meas(t[i][4], a, b, q);
      chk(a, t[i][5]);
      chk(b, t[i][6]);
      chk(q, t[i][7]);
    end
    $display("pwm test done");
  endtask

  task automatic t_oneshot;
    int a, b, q;
    cfg(11'h1, 16'h8, 16'ha, 16'h5, 8'h0);
    meas(7, a, b, q);
    chk(q, 1);
    meas(5, a, b, q);
    chk(q, 0);
    $display("one-shot test done");
  endtask

  task automatic t_capture;
    logic [1:0] tic [3] = '{2'h0, `PCT_TIC_CAP_ONLY, `PCT_TIC_RLD_ONLY};
    int e [3] = '{2, 1, 1};
    int q;
    for (int i = 0; i < 3; i++)
    begin
      cfg({1'h0, tic[i], 8'h05}, 16'h1, 16'h1e, 16'h0, 8'h0);
      q = c_irq;
      repeat (35) @(posedge clk);
      apb(1'h0, `PCT_OFF_PWM, 32'h0);
      chk(rv, 32'h0);
      cap <= 1'h1;
      @(posedge clk);
      cap <= 1'h0;
      apb(1'h0, `PCT_OFF_PWM, 32'h0);
      chk(rv >= 32'h6 && rv <= 32'he, 1'h1);
      repeat (2) @(posedge clk);
      chk(c_irq - q, e[i]);
    end
    $display("capture test done");
  endtask

  task automatic t_compare;
    int a, b, q;
    cfg(11'h407, 16'hfff0, 16'h6, 16'h0, 8'h0);
    meas(40, a, b, q);
    chk(q, 1);
    chk({o, on}, 2'h2);
    apb(1'h0, `PCT_OFF_COUNT, 32'h0);
    chk(rv >= 32'h10 && rv <= 32'h30, 1'h1);
    apb(1'h0, `PCT_OFF_STATUS, 32'h0);
    chk(rv, 32'h3);
    $display("compare test done");
  endtask

  // Reset in mid-run must clear the outputs and the control register
  task automatic t_reset;
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    chk({o, on, irq}, 3'h0);
    apb(1'h0, `PCT_OFF_CTRL, 32'h0);
    chk(rv, 32'h0);
    $display("reset test done");
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_pwm;
    t_oneshot;
    t_capture;
    t_compare;
    t_reset;
    summarize;
  end

  // Whole run needs about one thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize;
  end
endmodule // test_pwm_compare_capture_timer

`default_nettype wire
